// [include/ibc_pkg.sv]
// ibc_pkg: shared types and constants of the expansion bus cycle controller
// assumes a single core clock; all bus inputs already synchronous to it
package ibc_pkg;

  // ============================================================
  // widths
  localparam int IBC_ADDR_W = 24;
  localparam int IBC_BE_W = 4;
  localparam int IBC_WADDR_W = IBC_ADDR_W - 2;
  localparam int IBC_REF_ROW_W = 8;
  localparam int IBC_FIFO_DEPTH = 8;

  // ============================================================
  // cycle kinds; the two dma kinds are fly-by
  typedef enum logic [2:0] {
    IBC_MEM_RD,
    IBC_MEM_WR,
    IBC_IO_RD,
    IBC_IO_WR,
    IBC_DMA_IORD,
    IBC_DMA_IOWR
  } ibc_kind_t;

  typedef enum logic [1:0] {
    IBC_IDLE,
    IBC_ADDR,
    IBC_CMD,
    IBC_RECOV
  } ibc_phase_t;

  // ============================================================
  // carriers
  typedef struct packed {
    ibc_kind_t kind;
    logic [IBC_WADDR_W-1:0] word_addr;
    logic [IBC_BE_W-1:0] be;
  } ibc_req_t;

  localparam int IBC_REQ_W = $bits(ibc_req_t);

  typedef struct packed {
    logic done;
    logic aborted;
    logic refresh;
    ibc_kind_t kind;
    logic wide;
  } ibc_resp_t;

  typedef struct packed {
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
    logic refresh_n;
  } ibc_strobe_t;

  typedef struct packed {
    logic resetdrv;
    logic aen;
    logic bale;
    logic bclk;
    ibc_strobe_t strb;
    logic [IBC_ADDR_W-1:0] sys_addr;
  } ibc_bus_out_t;

  typedef struct packed {
    logic iochrdy;
    logic nows_n;
    logic iocs16_n;
    logic memcs16_n;
  } ibc_bus_in_t;

  // ============================================================
  // bus clock divisor select and values
  localparam logic [1:0] IBC_DIV_SEL_2 = 2'h0;
  localparam logic [1:0] IBC_DIV_SEL_3 = 2'h1;
  localparam logic [1:0] IBC_DIV_SEL_4 = 2'h2;
  localparam logic [1:0] IBC_DIV_SEL_6 = 2'h3;
  localparam logic [1:0] IBC_DIV_SEL_RST = IBC_DIV_SEL_4;
  localparam logic [2:0] IBC_DIV_VAL_2 = 3'h2;
  localparam logic [2:0] IBC_DIV_VAL_3 = 3'h3;
  localparam logic [2:0] IBC_DIV_VAL_4 = 3'h4;
  localparam logic [2:0] IBC_DIV_VAL_6 = 3'h6;
  localparam logic [2:0] IBC_HIGH_LEN_3 = 3'h1;

  // ============================================================
  // command lengths and extensions, in bus clock periods
  localparam logic [3:0] IBC_CMD_BCLKS_8 = 4'h4;
  localparam logic [3:0] IBC_CMD_BCLKS_16 = 4'h2;
  localparam logic [3:0] IBC_DMA_BCLKS = 4'h2;
  localparam logic [3:0] IBC_REF_BCLKS = 4'h2;
  localparam logic [3:0] IBC_EXT_NORM = 4'h1;
  localparam logic [3:0] IBC_EXT_DMA = 4'h2;
  localparam logic [3:0] IBC_RESETDRV_MIN_BCLKS = 4'ha;
  // one extra period covers the partial period at assertion
  localparam logic [3:0] IBC_RESETDRV_BCLKS = 4'(IBC_RESETDRV_MIN_BCLKS + 4'h1);

  localparam ibc_strobe_t IBC_STROBE_IDLE = '{ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1, memw_n: 1'b1, refresh_n: 1'b1};

endpackage : ibc_pkg

// [sim/ibc_card_model.sv]
// ibc_card_model: behavioural expansion card on the far side
// assumes open-collector lines: a released line reads at its pull-up level
`timescale 1ns/100ps
module ibc_card_model (
  input wire logic mclk_i,
  input wire ibc_pkg::ibc_bus_out_t bus_o,
  input wire logic [3:0] stall_i,
  input wire logic nows_i,
  input wire logic cs16_i,
  output ibc_pkg::ibc_bus_in_t bus_i
);
  import ibc_pkg::*;
  logic act;
  logic act_d = 1'b0;
  logic bclk_d = 1'b0;
  logic [3:0] left = 4'h0;
  // any strobe selects the card; in dma no address is looked at
  assign act = !(bus_o.strb.ior_n && bus_o.strb.iow_n && bus_o.strb.memr_n && bus_o.strb.memw_n);
  // wait counted in bus clocks from the strobe's start
  always @(posedge mclk_i) begin
    act_d <= act;
    bclk_d <= bus_o.bclk;
    if (act && !act_d) begin
      left <= stall_i;
    end else if (bus_o.bclk && !bclk_d && left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  // one driver for the whole struct; memory select is by address only
  assign bus_i = '{
    iochrdy: !(act && act_d && left != 4'h0),
    nows_n: !(nows_i && act),
    iocs16_n: !(cs16_i && !bus_o.aen && bus_o.sys_addr[15:2] == 14'h00c0),
    memcs16_n: !(cs16_i && bus_o.sys_addr[23:17] == 7'h05)
  };
endmodule : ibc_card_model

// [sim/ibc_ctrl_monitor.sv]
// ibc_ctrl_monitor: port-level assertions for the bus cycle controller
// assumes it is bound onto ibc_ctrl and sees only its ports
`timescale 1ns/100ps
module ibc_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire ibc_pkg::ibc_bus_out_t bus_o,
  input wire ibc_pkg::ibc_resp_t resp_o
);
  import ibc_pkg::*;
  // ====
  // helpers
  logic any_s;
  logic seen;
  logic [7:0] rd_cnt;
  logic [3:0] per;
  logic [3:0] hi;
  assign any_s = !(bus_o.strb.ior_n && bus_o.strb.iow_n && bus_o.strb.memr_n && bus_o.strb.memw_n);
  always_ff @(posedge mclk_i) begin
    if (rst_i || !bus_o.resetdrv) begin
      rd_cnt <= 8'h00;
    end else if ($rose(bus_o.bclk) && rd_cnt != 8'hff) begin
      rd_cnt <= rd_cnt + 8'h01;
    end
    if (rst_i) begin
      seen <= 1'b0;
      per <= 4'h0;
      hi <= 4'h0;
    end else if ($rose(bus_o.bclk)) begin
      seen <= 1'b1;
      per <= 4'h1;
      hi <= 4'h1;
    end else begin
      per <= per + 4'h1;
      hi <= hi + 4'(bus_o.bclk);
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // ====
  // assertions
  a_refresh_pair: assert property (!bus_o.strb.refresh_n |-> !bus_o.strb.memr_n && bus_o.aen && !bus_o.bale)
    else $error("refresh strobe without memory read or address enable");
  a_dma_aen: assert property ((!bus_o.strb.ior_n && !bus_o.strb.memw_n) || (!bus_o.strb.iow_n && !bus_o.strb.memr_n)
    |-> bus_o.aen && bus_o.bale)
    else $error("fly-by strobes without address enable and latch enable");
  a_dma_pair: assert property (bus_o.aen && bus_o.strb.refresh_n && any_s |->
    (!bus_o.strb.ior_n && !bus_o.strb.memw_n && bus_o.strb.iow_n && bus_o.strb.memr_n) ||
    (!bus_o.strb.iow_n && !bus_o.strb.memr_n && bus_o.strb.ior_n && bus_o.strb.memw_n))
    else $error("dma strobe pairing wrong");
  a_bale_norm: assert property (any_s && !bus_o.aen |-> !bus_o.bale)
    else $error("latch enable high during normal command");
  a_addr_hold: assert property (any_s && $past(any_s) |-> $stable(bus_o.sys_addr))
    else $error("address moved during command");
  a_resetdrv_len: assert property ($fell(bus_o.resetdrv) |-> rd_cnt >= 8'd10)
    else $error("bus reset shorter than ten bus clocks");
  a_bclk_duty: assert property ($rose(bus_o.bclk) && seen |->
    (per == 4'd3 && hi == 4'd1) || ((per == 4'd2 || per == 4'd4 || per == 4'd6) && {hi, 1'b0} == {1'b0, per}))
    else $error("bus clock period or duty wrong");
  a_dma_narrow: assert property (resp_o.done && !resp_o.aborted && !resp_o.refresh &&
    (resp_o.kind == IBC_DMA_IORD || resp_o.kind == IBC_DMA_IOWR) |-> !resp_o.wide)
    else $error("dma cycle reported wide");
endmodule : ibc_ctrl_monitor

bind ibc_ctrl ibc_ctrl_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .bus_o(bus_o), .resp_o(resp_o));

// [sim/test_isa_bus_cycle_controller.sv]
// test_isa_bus_cycle_controller: self-checking bench for ibc_ctrl
// assumes ibc_card_model answers on the bus side
`timescale 1ns/100ps
module test_isa_bus_cycle_controller;
  import ibc_pkg::*;
  logic mclk_i = 0, rst_i = 1, req_valid_i = 0, div_load_i = 0, refresh_disable_i = 0, refresh_req_i = 0;
  logic bus_reset_i = 0, nows = 0, cs16 = 1, req_ready_o, busy_o, refresh_lost_o, ls;
  logic [1:0] div_sel_i = 2'h0;
  logic [3:0] stall = 4'h0;
  ibc_req_t req_i = '0;
  ibc_bus_in_t bus_i;
  ibc_bus_out_t bus_o;
  ibc_resp_t resp_o;
  int bad_count = 0, n_tests = 0, cyc = 0, n, h, p, c0, i;
  ibc_ctrl #(.FIFO_DEPTH(IBC_FIFO_DEPTH)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .div_load_i(div_load_i), .div_sel_i(div_sel_i),
    .refresh_disable_i(refresh_disable_i), .refresh_req_i(refresh_req_i), .bus_reset_i(bus_reset_i),
    .bus_i(bus_i), .bus_o(bus_o), .resp_o(resp_o), .busy_o(busy_o), .refresh_lost_o(refresh_lost_o));
  ibc_card_model u_card (.mclk_i(mclk_i), .bus_o(bus_o), .stall_i(stall), .nows_i(nows), .cs16_i(cs16),
    .bus_i(bus_i));
  initial forever #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  // ====
  // shared tasks
  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_ok(input string nm, input bit ok, input int v);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH %s expected in range seen %0d", nm, v);
    end
  endtask : cmp_ok
  function automatic logic probe(input int c);
    case (c)
      0: return !(bus_o.strb.ior_n & bus_o.strb.iow_n & bus_o.strb.memr_n & bus_o.strb.memw_n);
      1: return resp_o.done;
      2: return !busy_o;
      3: return !bus_o.resetdrv;
      4: return bus_o.bclk;
      default: return !bus_o.bclk;
    endcase
  endfunction : probe
  task automatic wait_for(input int c);
    int k;
    for (k = 0; k < 4000 && probe(c) !== 1'b1; k++) @(negedge mclk_i);
    if (k == 4000) begin
      bad_count++;
      $display("MISMATCH wait %0d expected event seen timeout", c);
      end_sim();
    end
  endtask : wait_for
  task automatic count(input int c, output int k);
    k = 0;
    while (probe(c) === 1'b1 && k < 4000) begin
      @(negedge mclk_i);
      k++;
    end
    if (k == 4000) begin
      bad_count++;
      $display("MISMATCH count %0d expected end seen timeout", c);
      end_sim();
    end
  endtask : count
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask : pulse
  task automatic push(input ibc_kind_t k, input logic [21:0] wa, input logic [3:0] be);
    int j;
    @(negedge mclk_i);
    req_i = '{kind: k, word_addr: wa, be: be};
    req_valid_i = 1'b1;
    for (j = 0; j < 4000 && req_ready_o !== 1'b1; j++) @(negedge mclk_i);
    if (j == 4000) begin
      bad_count++;
      $display("MISMATCH req_ready_o expected 1 seen timeout");
      end_sim();
    end
    @(negedge mclk_i);
    req_valid_i = 1'b0;
  endtask : push
  task automatic meas_bclk(output int hh, output int pp);
    int l;
    wait_for(5);
    wait_for(4);
    count(4, hh);
    count(5, l);
    pp = hh + l;
  endtask : meas_bclk
  task automatic run1(input ibc_kind_t k, input logic [3:0] st, input logic nw, output int m);
    stall = st;
    nows = nw;
    push(k, 22'h0000c0, 4'h1);
    wait_for(0);
    count(0, m);
    wait_for(2);
  endtask : run1
  task automatic count_ref(output int m);
    m = 0;
    repeat (300) begin
      @(negedge mclk_i);
      if (bus_o.strb.refresh_n === 1'b0) m++;
    end
  endtask : count_ref
  // ====
  // scenarios
  task automatic t_fill_drain;
    ibc_kind_t tk[8] = '{IBC_MEM_RD, IBC_IO_RD, IBC_IO_WR, IBC_MEM_WR, IBC_DMA_IORD, IBC_DMA_IOWR, IBC_IO_RD,
      IBC_MEM_RD};
    logic [21:0] tw[8] = '{22'h028000, 22'h028000, 22'h0000c0, 22'h0000c0, 22'h0280c0, 22'h0280c0, 22'h0280c0,
      22'h0280c0};
    logic [3:0] tb[8] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'hc, 4'h6, 4'hf};
    logic [1:0] ta[8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
    logic [7:0] wd = 8'hc5;
    c0 = cyc;
    stall = 4'h2;
    for (i = 0; i < 8; i++) push(tk[i], tw[i], tb[i]);
    cmp("req_ready_o", 1'b0, req_ready_o);
    meas_bclk(h, p);
    cmp("bclk_high", 2, h);
    cmp("bclk_period", 4, p);
    wait_for(3);
    cmp_ok("resetdrv_len", cyc - c0 >= 40, cyc - c0);
    for (i = 0; i < 8; i++) begin
      wait_for(1);
      cmp("kind", tk[i], resp_o.kind);
      cmp("wide", wd[i], resp_o.wide);
      cmp("sys_addr", {tw[i], ta[i]}, bus_o.sys_addr);
      @(negedge mclk_i);
    end
    wait_for(2);
    cmp("req_ready_o", 1'b1, req_ready_o);
  endtask : t_fill_drain
  task automatic t_divisor;
    logic [1:0] s[3] = '{IBC_DIV_SEL_3, IBC_DIV_SEL_6, IBC_DIV_SEL_2};
    int eh[3] = '{1, 3, 1};
    int ep[3] = '{3, 6, 2};
    for (i = 0; i < 3; i++) begin
      div_sel_i = s[i];
      pulse(div_load_i);
      repeat (8) @(negedge mclk_i);
      meas_bclk(h, p);
      cmp("bclk_high", eh[i], h);
      cmp("bclk_period", ep[i], p);
    end
  endtask : t_divisor
  task automatic t_cycle_len;
    run1(IBC_MEM_RD, 4'h0, 1'b0, n);
    cmp("mem_len", 8, n);
    run1(IBC_MEM_RD, 4'h6, 1'b0, n);
    cmp_ok("mem_ext", n > 8 && n % 2 == 0, n);
    run1(IBC_MEM_RD, 4'h0, 1'b1, n);
    cmp_ok("mem_nows", n < 8, n);
    run1(IBC_MEM_RD, 4'h6, 1'b1, n);
    cmp_ok("nows_vs_rdy", n > 8, n);
    run1(IBC_DMA_IORD, 4'h0, 1'b1, n);
    cmp("dma_len", 4, n);
    run1(IBC_DMA_IOWR, 4'h6, 1'b0, n);
    cmp_ok("dma_ext", n > 4 && n % 4 == 0, n);
    nows = 1'b0;
  endtask : t_cycle_len
  task automatic t_refresh;
    stall = 4'h0;
    pulse(refresh_req_i);
    wait_for(0);
    count(0, n);
    cmp("refresh_len", 4, n);
    cmp("refresh_flag", 1'b1, resp_o.refresh);
    wait_for(2);
    stall = 4'hf;
    push(IBC_MEM_RD, 22'h0000c0, 4'h1);
    wait_for(0);
    pulse(refresh_req_i);
    pulse(refresh_req_i);
    ls = refresh_lost_o;
    stall = 4'h0;
    @(negedge mclk_i);
    cmp("refresh_lost", 1'b1, ls | refresh_lost_o);
    count_ref(n);
    cmp("refresh_count", 4, n);
    refresh_disable_i = 1'b1;
    pulse(refresh_req_i);
    count_ref(n);
    cmp("refresh_off", 0, n);
    refresh_disable_i = 1'b0;
  endtask : t_refresh
  task automatic t_bus_reset;
    stall = 4'hf;
    push(IBC_MEM_RD, 22'h0000c0, 4'h1);
    wait_for(0);
    pulse(bus_reset_i);
    c0 = cyc;
    wait_for(1);
    cmp("aborted", 1'b1, resp_o.aborted);
    wait_for(3);
    cmp_ok("resetdrv_bus", cyc - c0 >= 20, cyc - c0);
    stall = 4'h0;
  endtask : t_bus_reset
  initial begin
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    t_fill_drain();
    t_divisor();
    t_cycle_len();
    t_refresh();
    t_bus_reset();
    end_sim();
  end
endmodule : test_isa_bus_cycle_controller

// [src/ibc_ctrl.sv]
// ibc_ctrl: expansion bus cycle controller, bus clock, strobes, refresh and bus reset
// assumes bus inputs already synchronous to mclk_i; pin wires resolved outside
`timescale 1ns/100ps

// Functional notes
// R1 - address enable high through every dma and refresh cycle
// R2 - dma is fly-by: io read with memory write, io write with memory read
// R3 - io cards must ignore addresses while address enable is high
// R4 - io cards in dma select themselves by their acknowledge line
// R5 - latch enable pulses at start of normal cycles, held whole dma cycle
// R6 - all 24 address lines driven together and held for the whole cycle
// R7 - bus clock is core clock over 2, 3, 4 or 6; third-duty at 3
// R8 - no-wait input sampled on bus clock only in memory and io cycles
// R9 - ready negated overrides an asserted no-wait request
// R10 - normal cycles stretch by whole bus clock periods while not ready
// R11 - dma cycles stretch by even numbers of bus clock periods
// R12 - one refresh request pending at most; later ones are dropped
// R13 - cards pull ready low soon after a strobe and release it when done
// R14 - io 16-bit select honoured only in io cycles
// R15 - io cards drive their 16-bit select from a plain address decode
// R16 - memory 16-bit select honoured only in memory cycles
// R17 - memory cards decode 16-bit select from address lines, maybe upper only
// R18 - io strobes address io cards in io cycles, acknowledged cards in dma
// R19 - memory cards answer only by address, never by dma acknowledge
// R20 - refresh strobe asserted with memory read, driven totem-pole
// R21 - a configuration input disables refresh cycles entirely
// R22 - bus reset held at least ten bus clock periods
// R23 - divisor chosen by configuration, resets to a moderate default
// R24 - low two address lines come from the byte enables
module ibc_ctrl #(
  parameter int FIFO_DEPTH = ibc_pkg::IBC_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire ibc_pkg::ibc_req_t req_i,
  input wire logic div_load_i,
  input wire logic [1:0] div_sel_i,
  input wire logic refresh_disable_i,
  input wire logic refresh_req_i,
  input wire logic bus_reset_i,
  input wire ibc_pkg::ibc_bus_in_t bus_i,
  output ibc_pkg::ibc_bus_out_t bus_o,
  output ibc_pkg::ibc_resp_t resp_o,
  output logic busy_o,
  output logic refresh_lost_o
);
  import ibc_pkg::*;

  typedef struct packed {
    ibc_phase_t phase;
    logic [2:0] bclk_cnt;
    logic [1:0] div_sel;
    logic [1:0] div_pend;
    logic div_chg;
    ibc_kind_t kind;
    logic is_ref;
    logic wide;
    logic [3:0] wait_cnt;
    logic ref_pend;
    logic ref_lost;
    logic [IBC_REF_ROW_W-1:0] ref_row;
    logic [3:0] rst_cnt;
    logic busy;
    ibc_bus_out_t bus;
    ibc_resp_t resp;
  } ibc_ctrl_state_t;

  ibc_ctrl_state_t s;
  ibc_ctrl_state_t next_s;

  logic fifo_valid;
  logic fifo_pop;
  ibc_req_t fifo_data;
  logic [IBC_REQ_W-1:0] fifo_word;

  logic tick;
  logic ref_start;
  logic [2:0] div_val;
  logic [2:0] high_len;
  logic cur_dma;

  // ============================================================
  // request queue; a stalled bus backs up into the requester
  ibc_fifo #(
    .WIDTH(IBC_REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i(req_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_word)
  );

  assign fifo_data = ibc_req_t'(fifo_word);

  // ============================================================
  // low address bits from the lowest enabled byte lane
  function automatic logic [1:0] be_to_low(input logic [IBC_BE_W-1:0] be);
    logic [1:0] r;
    r = 2'h0;
    if (be[0]) begin
      r = 2'h0;
    end else if (be[1]) begin
      r = 2'h1;
    end else if (be[2]) begin
      r = 2'h2;
    end else if (be[3]) begin
      r = 2'h3;
    end
    return r;
  endfunction : be_to_low

  function automatic logic kind_is_dma(input ibc_kind_t k);
    return (k == IBC_DMA_IORD) || (k == IBC_DMA_IOWR);
  endfunction : kind_is_dma

  // ============================================================
  // next state
  always_comb begin
    next_s = s;
    tick = 1'b0;
    ref_start = 1'b0;
    fifo_pop = 1'b0;
    next_s.resp.done = 1'b0;
    next_s.resp.aborted = 1'b0;
    next_s.ref_lost = 1'b0;
    cur_dma = kind_is_dma(s.kind) && !s.is_ref;

    // bus clock divider
    unique case (s.div_sel)
      IBC_DIV_SEL_2: div_val = IBC_DIV_VAL_2; // R7
      IBC_DIV_SEL_3: div_val = IBC_DIV_VAL_3; // R7
      IBC_DIV_SEL_4: div_val = IBC_DIV_VAL_4; // R7
      IBC_DIV_SEL_6: div_val = IBC_DIV_VAL_6; // R7
    endcase
    // divide by 3 gives one high of three; the rest are half duty
    high_len = (s.div_sel == IBC_DIV_SEL_3) ? IBC_HIGH_LEN_3 : 3'(div_val >> 1); // R7
    if (s.bclk_cnt >= 3'(div_val - 3'h1)) begin
      next_s.bclk_cnt = 3'h0;
      tick = 1'b1;
    end else begin
      next_s.bclk_cnt = 3'(s.bclk_cnt + 3'h1);
    end
    next_s.bus.bclk = next_s.bclk_cnt < high_len; // R7

    // divisor change only between cycles so no cycle sees two rates
    if (tick && s.div_chg && (s.phase == IBC_IDLE)) begin
      next_s.div_sel = s.div_pend; // R23
      next_s.div_chg = 1'b0;
    end
    if (div_load_i) begin
      next_s.div_pend = div_sel_i; // R23
      next_s.div_chg = 1'b1;
    end

    // bus reset length, counted in bus clock periods
    if (tick && (s.rst_cnt != 4'h0)) begin
      next_s.rst_cnt = 4'(s.rst_cnt - 4'h1); // R22
      if (next_s.rst_cnt == 4'h0) begin
        next_s.bus.resetdrv = 1'b0; // R22
      end
    end

    // cycle sequencer, one step per bus clock period
    if (tick) begin
      unique case (s.phase)
        IBC_IDLE: begin
          if (s.rst_cnt == 4'h0) begin
            if (s.ref_pend && !refresh_disable_i) begin
              ref_start = 1'b1;
              next_s.is_ref = 1'b1;
              next_s.wide = 1'b0;
              next_s.bus.aen = 1'b1; // R1
              next_s.bus.sys_addr = {{(IBC_ADDR_W - IBC_REF_ROW_W){1'b0}}, s.ref_row}; // R6
              next_s.ref_row = IBC_REF_ROW_W'(s.ref_row + 1'b1);
              next_s.phase = IBC_ADDR;
            end else if (fifo_valid) begin
              fifo_pop = 1'b1;
              next_s.is_ref = 1'b0;
              next_s.kind = fifo_data.kind;
              next_s.wide = 1'b0;
              next_s.bus.sys_addr = {fifo_data.word_addr, be_to_low(fifo_data.be)}; // R6 R24
              next_s.bus.aen = kind_is_dma(fifo_data.kind); // R1
              next_s.bus.bale = 1'b1; // R5
              next_s.phase = IBC_ADDR;
            end
          end
        end
        IBC_ADDR: begin
          next_s.bus.bale = cur_dma; // R5
          next_s.phase = IBC_CMD;
          if (s.is_ref) begin
            next_s.bus.strb.memr_n = 1'b0; // R20
            next_s.bus.strb.refresh_n = 1'b0; // R20
            next_s.wait_cnt = IBC_REF_BCLKS;
          end else begin
            unique case (s.kind)
              IBC_MEM_RD, IBC_MEM_WR: begin
                next_s.wide = !bus_i.memcs16_n; // R16
                next_s.bus.strb.memr_n = s.kind != IBC_MEM_RD;
                next_s.bus.strb.memw_n = s.kind != IBC_MEM_WR;
              end
              IBC_IO_RD, IBC_IO_WR: begin
                next_s.wide = !bus_i.iocs16_n; // R14
                next_s.bus.strb.ior_n = s.kind != IBC_IO_RD; // R18
                next_s.bus.strb.iow_n = s.kind != IBC_IO_WR; // R18
              end
              IBC_DMA_IORD: begin
                next_s.bus.strb.ior_n = 1'b0; // R2 R18
                next_s.bus.strb.memw_n = 1'b0; // R2
              end
              IBC_DMA_IOWR: begin
                next_s.bus.strb.iow_n = 1'b0; // R2 R18
                next_s.bus.strb.memr_n = 1'b0; // R2
              end
              default: begin
                next_s.phase = IBC_RECOV;
              end
            endcase
            if (cur_dma) begin
              next_s.wait_cnt = IBC_DMA_BCLKS;
            end else begin
              next_s.wait_cnt = next_s.wide ? IBC_CMD_BCLKS_16 : IBC_CMD_BCLKS_8;
            end
          end
        end
        IBC_CMD: begin
          if ((s.wait_cnt <= 4'h1) && !bus_i.iochrdy) begin
            // not ready at the end point: stretch, dma by two periods
            next_s.wait_cnt = cur_dma ? IBC_EXT_DMA : IBC_EXT_NORM; // R9 R10 R11 R13
          end else if ((s.wait_cnt <= 4'h1) || (!s.is_ref && !cur_dma && !bus_i.nows_n && bus_i.iochrdy)) begin
            next_s.bus.strb = IBC_STROBE_IDLE; // R8 R9
            next_s.bus.aen = 1'b0; // R1
            next_s.bus.bale = 1'b0; // R5
            next_s.resp.done = 1'b1;
            next_s.resp.refresh = s.is_ref;
            next_s.resp.kind = s.kind;
            next_s.resp.wide = s.wide;
            next_s.phase = IBC_RECOV;
          end else begin
            next_s.wait_cnt = 4'(s.wait_cnt - 4'h1);
          end
        end
        IBC_RECOV: begin
          next_s.phase = IBC_IDLE;
        end
      endcase
    end

    // single pending refresh; a new request beats the clear
    if (ref_start) begin
      next_s.ref_pend = 1'b0;
    end
    if (refresh_req_i && !refresh_disable_i) begin
      if (s.ref_pend && !ref_start) begin
        next_s.ref_lost = 1'b1; // R12
      end
      next_s.ref_pend = 1'b1; // R12
    end
    if (refresh_disable_i) begin
      next_s.ref_pend = 1'b0; // R21
    end

    // bus reset request aborts any cycle in flight
    if (bus_reset_i) begin
      next_s.rst_cnt = IBC_RESETDRV_BCLKS; // R22
      next_s.bus.resetdrv = 1'b1; // R22
      next_s.bus.strb = IBC_STROBE_IDLE;
      next_s.bus.aen = 1'b0;
      next_s.bus.bale = 1'b0;
      next_s.phase = IBC_IDLE;
      fifo_pop = 1'b0;
      ref_start = 1'b0;
      if (s.phase != IBC_IDLE) begin
        next_s.resp.done = 1'b1;
        next_s.resp.aborted = 1'b1;
        next_s.resp.refresh = s.is_ref;
        next_s.resp.kind = s.kind;
      end
    end

    next_s.busy = next_s.phase != IBC_IDLE;

    if (rst_i) begin
      next_s = '0;
      next_s.phase = IBC_IDLE;
      next_s.kind = IBC_MEM_RD;
      next_s.div_sel = IBC_DIV_SEL_RST; // R23
      next_s.div_pend = IBC_DIV_SEL_RST;
      next_s.rst_cnt = IBC_RESETDRV_BCLKS; // R22
      next_s.bus.resetdrv = 1'b1; // R22
      next_s.bus.strb = IBC_STROBE_IDLE;
      next_s.resp.kind = IBC_MEM_RD;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge mclk_i) begin
    s <= next_s;
  end

  // ============================================================
  // outputs, all straight from the state register
  assign bus_o = s.bus; // R20
  assign resp_o = s.resp;
  assign busy_o = s.busy;
  assign refresh_lost_o = s.ref_lost;

endmodule : ibc_ctrl

// [src/ibc_fifo.sv]
// ibc_fifo: request queue in front of the bus cycle sequencer
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
module ibc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic not_full;
    logic not_empty;
  } ibc_fifo_state_t;

  ibc_fifo_state_t s;
  ibc_fifo_state_t next_s;
  logic push;
  logic pop;

  // ============================================================
  // next state; wrap by compare so any depth works
  always_comb begin
    next_s = s;
    push = in_valid_i && s.not_full;
    pop = out_ready_i && s.not_empty;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = (s.wr_ptr == LAST) ? '0 : PTR_W'(s.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == LAST) ? '0 : PTR_W'(s.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_s.count = CNT_W'(s.count + 1'b1);
    end else if (pop && !push) begin
      next_s.count = CNT_W'(s.count - 1'b1);
    end
    next_s.not_full = next_s.count != FULL;
    next_s.not_empty = next_s.count != '0;
    if (rst_i) begin
      next_s = '0;
      next_s.not_full = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign in_ready_o = s.not_full;
  assign out_valid_o = s.not_empty;
  assign out_data_o = s.mem[s.rd_ptr];

endmodule : ibc_fifo
